/* File: src/mma_pkg.sv */
// Constants for the auxiliary command block of the position module.
// Assumes a 250 MHz system clock and an Avalon-MM register master.
`default_nettype none
package mma_pkg;
    // ****************************************************
    // Register map (byte addresses)
    // ****************************************************
    localparam logic [5:0] ADDR_CMD      = 6'h00;
    localparam logic [5:0] ADDR_STATUS   = 6'h04;
    localparam logic [5:0] ADDR_NEW_POS  = 6'h08;
    localparam logic [5:0] ADDR_CUR_POS  = 6'h0c;
    localparam logic [5:0] ADDR_RAMP_UP  = 6'h10;
    localparam logic [5:0] ADDR_RAMP_DN  = 6'h14;
    localparam logic [5:0] ADDR_SMOOTH   = 6'h18;
    localparam logic [5:0] ADDR_INHIBIT  = 6'h1c;
    localparam logic [5:0] ADDR_CFG_PTR  = 6'h20;
    localparam logic [5:0] ADDR_CFG_DATA = 6'h24;
    localparam logic [5:0] ADDR_UNITS    = 6'h28;
    localparam logic [5:0] ADDR_ACT_CFG  = 6'h2c;
    // ****************************************************
    // Command codes and fields
    // ****************************************************
    localparam logic [2:0] CMD_LOAD_LOC  = 3'h1;
    localparam logic [2:0] CMD_RAMP      = 3'h2;
    localparam logic [2:0] CMD_CLEAR     = 3'h3;
    localparam logic [2:0] CMD_RELOAD    = 3'h4;
    localparam int         STAT_DONE_BIT = 0;
    localparam int         STAT_BUSY_BIT = 1;
    localparam int         STAT_ERR_LSB  = 8;
    localparam int         STAT_ACT_BIT  = 16;
    localparam int         STAT_CLR_BIT  = 17;
    // ****************************************************
    // Error results
    // ****************************************************
    localparam logic [7:0] ERR_NONE      = 8'h00;
    localparam logic [7:0] ERR_BAD_CMD   = 8'h01;
    localparam logic [7:0] ERR_BAD_RAMP  = 8'h02;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int         CLK_MHZ       = 250;
    localparam int         CLR_PULSE_MS  = 50;
    localparam int         CLR_PULSE_CYC = CLR_PULSE_MS * 1000 * CLK_MHZ;
    localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: src/mma_aux_commands.sv */
// Auxiliary command engine of the position module.
// Assumes an Avalon-MM master on the same clock and an external config table.
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`default_nettype none
module mma_aux_commands #(
    parameter int CLR_CYCLES = mma_pkg::CLR_PULSE_CYC
) (
    input  wire logic        sys_clk_in,         // 250 MHz clock
    input  wire logic        sys_rst_in,         // Sync reset, high
    input  wire logic [5:0]  avs_address_in,     // Byte address
    input  wire logic        avs_read_in,        // Read strobe
    input  wire logic        avs_write_in,       // Write strobe
    input  wire logic [31:0] avs_writedata_in,   // Write data
    input  wire logic [3:0]  avs_byteenable_in,  // Byte lanes
    output logic [31:0]      avs_readdata_out,   // Read data
    output logic             avs_waitrequest_out, // Stall
    input  wire logic [31:0] cfg_rdata_in,       // Config table word
    output logic [31:0]      cfg_addr_out,       // Config table address
    output logic             cfg_rd_out,         // Config table read
    output logic [31:0]      actual_location_report_out, // Current position
    output logic [31:0]      ramp_up_duration_out,   // Active accel ms
    output logic [31:0]      ramp_down_duration_out, // Active decel ms
    output logic [31:0]      smoothing_duration_out, // Active jerk ms
    output logic             drive_inhibit_pin_out,  // Motor disable
    output logic             clear_pulse_pin_out,    // Clear pulse
    output logic             cfg_changed_out     // Setup recalculation pulse
);
    // ****************************************************
    // State
    // ****************************************************
    typedef enum logic [4:0] {
        MMA_IDLE  = 5'b00001,
        MMA_EXEC  = 5'b00010,
        MMA_PULSE = 5'b00100,
        MMA_FETCH = 5'b01000,
        MMA_DONE  = 5'b10000
    } mma_state_t;

    mma_state_t  state;
    mma_state_t  next_state;
    logic [2:0]  cmd;
    logic        done;
    logic [7:0]  err;
    logic [31:0] new_pos;
    logic [31:0] cur_pos;
    logic [31:0] tbl_up;
    logic [31:0] tbl_dn;
    logic [31:0] tbl_sm;
    logic [31:0] cfg_ptr;
    logic [31:0] act_cfg;
    logic        units_real;
    logic [7:0]  inhibit_req;
    logic        inhibit_en;
    logic [31:0] clr_cnt;
    logic        rd_pend;
    logic        fetch_wait;
    logic        start_cmd;
    logic [31:0] wmask;
    logic        ramp_neg;

    assign start_cmd = avs_write_in && (avs_address_in == mma_pkg::ADDR_CMD)
                       && avs_byteenable_in[0] && (avs_writedata_in[2:0] != 3'h0);
    assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    // Any negative ramp time refuses the whole set
    assign ramp_neg = tbl_up[31] || tbl_dn[31] || tbl_sm[31];

    // ****************************************************
    // Bus slave: writes in zero wait, reads one wait
    // ****************************************************
    // Read stalls one cycle while read data loads
    assign avs_waitrequest_out = avs_read_in && !rd_pend;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= avs_read_in && !rd_pend;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !rd_pend) begin
            case (avs_address_in)
                mma_pkg::ADDR_STATUS: begin
                    avs_readdata_out <= 32'h0000_0000;
                    avs_readdata_out[mma_pkg::STAT_DONE_BIT] <= done;
                    avs_readdata_out[mma_pkg::STAT_BUSY_BIT] <= (state != MMA_IDLE);
                    avs_readdata_out[mma_pkg::STAT_ERR_LSB +: 8] <= err;
                    avs_readdata_out[mma_pkg::STAT_ACT_BIT] <= drive_inhibit_pin_out;
                    avs_readdata_out[mma_pkg::STAT_CLR_BIT] <= clear_pulse_pin_out;
                end
                mma_pkg::ADDR_NEW_POS:  avs_readdata_out <= new_pos;
                mma_pkg::ADDR_CUR_POS:  avs_readdata_out <= cur_pos;
                mma_pkg::ADDR_RAMP_UP:  avs_readdata_out <= tbl_up;
                mma_pkg::ADDR_RAMP_DN:  avs_readdata_out <= tbl_dn;
                mma_pkg::ADDR_SMOOTH:   avs_readdata_out <= tbl_sm;
                mma_pkg::ADDR_INHIBIT:  avs_readdata_out <= {23'h000000, inhibit_en, inhibit_req};
                mma_pkg::ADDR_CFG_PTR:  avs_readdata_out <= cfg_ptr;
                mma_pkg::ADDR_UNITS:    avs_readdata_out <= {31'h00000000, units_real};
                mma_pkg::ADDR_ACT_CFG:  avs_readdata_out <= act_cfg;
                default:                avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************
    // Software-written parameters
    // ****************************************************
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            new_pos     <= mma_pkg::RESET_ZERO;
            tbl_up      <= mma_pkg::RESET_ZERO;
            tbl_dn      <= mma_pkg::RESET_ZERO;
            tbl_sm      <= mma_pkg::RESET_ZERO;
            cfg_ptr     <= mma_pkg::RESET_ZERO;
            units_real  <= 1'b0;
            inhibit_req <= 8'h00;
            inhibit_en  <= 1'b0;
        end else if (avs_write_in) begin
            case (avs_address_in)
                mma_pkg::ADDR_NEW_POS: new_pos <= (new_pos & ~wmask) | (avs_writedata_in & wmask);
                mma_pkg::ADDR_RAMP_UP: tbl_up  <= (tbl_up & ~wmask) | (avs_writedata_in & wmask);
                mma_pkg::ADDR_RAMP_DN: tbl_dn  <= (tbl_dn & ~wmask) | (avs_writedata_in & wmask);
                mma_pkg::ADDR_SMOOTH:  tbl_sm  <= (tbl_sm & ~wmask) | (avs_writedata_in & wmask);
                mma_pkg::ADDR_CFG_PTR: cfg_ptr <= (cfg_ptr & ~wmask) | (avs_writedata_in & wmask);
                mma_pkg::ADDR_UNITS: begin
                    if (avs_byteenable_in[0]) begin
                        units_real <= avs_writedata_in[0];
                    end
                end
                mma_pkg::ADDR_INHIBIT: begin
                    if (avs_byteenable_in[0]) begin
                        inhibit_req <= avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        inhibit_en <= avs_writedata_in[8];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************
    // Drive inhibit: no handshake, follows request while inhibit_en is set
    // ****************************************************
    // Pin keeps its level while the instruction is disabled
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            drive_inhibit_pin_out <= 1'b0;
        end else if (inhibit_en) begin
            drive_inhibit_pin_out <= (inhibit_req != 8'h00);
        end
    end

    // ****************************************************
    // Command sequencer
    // ****************************************************
    // One pass through EXEC per accepted command
    always_comb begin
        next_state = state;
        case (state)
            MMA_IDLE: begin
                if (start_cmd) begin
                    next_state = MMA_EXEC;
                end
            end
            MMA_EXEC: begin
                case (cmd)
                    mma_pkg::CMD_CLEAR:  next_state = MMA_PULSE;
                    mma_pkg::CMD_RELOAD: next_state = MMA_FETCH;
                    default:             next_state = MMA_DONE;
                endcase
            end
            MMA_PULSE: begin
                if (clr_cnt == 32'h0000_0001) begin
                    next_state = MMA_DONE;
                end
            end
            MMA_FETCH: begin
                if (fetch_wait) begin
                    next_state = MMA_DONE;
                end
            end
            MMA_DONE: next_state = MMA_IDLE;
            default:  next_state = MMA_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state <= MMA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Requests while busy are dropped
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cmd <= 3'h0;
        end else if (state == MMA_IDLE && start_cmd) begin
            cmd <= avs_writedata_in[2:0];
        end
    end

    // Done stays until the next accepted command
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            done <= 1'b0;
        end else if (state == MMA_IDLE && start_cmd) begin
            done <= 1'b0;
        end else if (state == MMA_DONE) begin
            done <= 1'b1;
        end
    end

    // Result stays until the next command executes
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            err <= mma_pkg::ERR_NONE;
        end else if (state == MMA_EXEC) begin
            case (cmd)
                mma_pkg::CMD_LOAD_LOC, mma_pkg::CMD_CLEAR, mma_pkg::CMD_RELOAD: err <= mma_pkg::ERR_NONE;
                mma_pkg::CMD_RAMP: err <= ramp_neg ? mma_pkg::ERR_BAD_RAMP : mma_pkg::ERR_NONE;
                default:           err <= mma_pkg::ERR_BAD_CMD;
            endcase
        end
    end

    // ****************************************************
    // Position and ramp registers
    // ****************************************************
    // Raw 32 bits kept whatever the units
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cur_pos <= mma_pkg::RESET_ZERO;
        end else if (state == MMA_EXEC && cmd == mma_pkg::CMD_LOAD_LOC) begin
            cur_pos <= new_pos;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            actual_location_report_out <= mma_pkg::RESET_ZERO;
        end else begin
            // Trails the stored position by one cycle
            actual_location_report_out <= cur_pos;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ramp_up_duration_out   <= mma_pkg::RESET_ZERO;
            ramp_down_duration_out <= mma_pkg::RESET_ZERO;
            smoothing_duration_out <= mma_pkg::RESET_ZERO;
        end else if (state == MMA_EXEC && cmd == mma_pkg::CMD_RAMP && !ramp_neg) begin
            // All three adopted together or none
            ramp_up_duration_out   <= tbl_up;
            ramp_down_duration_out <= tbl_dn;
            smoothing_duration_out <= tbl_sm;
        end
    end

    // ****************************************************
    // Clear pulse timer
    // ****************************************************
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            clr_cnt <= 32'h0000_0000;
        end else if (state == MMA_EXEC && cmd == mma_pkg::CMD_CLEAR) begin
            clr_cnt <= 32'(CLR_CYCLES);
        end else if (state == MMA_PULSE) begin
            clr_cnt <= clr_cnt - 32'h0000_0001;
        end
    end

    // Pin drops on the last counted cycle
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            clear_pulse_pin_out <= 1'b0;
        end else if (state == MMA_EXEC && cmd == mma_pkg::CMD_CLEAR) begin
            clear_pulse_pin_out <= 1'b1;
        end else if (state == MMA_PULSE) begin
            clear_pulse_pin_out <= (clr_cnt != 32'h0000_0001);
        end
    end

    // ****************************************************
    // Configuration reload
    // ****************************************************
    assign cfg_addr_out = cfg_ptr;
    assign cfg_rd_out   = (state == MMA_FETCH) && !fetch_wait;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            fetch_wait <= 1'b0;
        end else begin
            fetch_wait <= (state == MMA_FETCH) && !fetch_wait;
        end
    end

    // Only a differing word is applied
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            act_cfg         <= mma_pkg::RESET_ZERO;
            cfg_changed_out <= 1'b0;
        end else begin
            cfg_changed_out <= 1'b0;
            if (state == MMA_FETCH && fetch_wait && cfg_rdata_in != act_cfg) begin
                act_cfg         <= cfg_rdata_in;
                cfg_changed_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/mma_aux_props.sv */
// Port checker for the auxiliary command block.
// Assumes binding onto mma_aux_commands, one clock domain.
`default_nettype none
module mma_aux_props #(
    parameter int CLR_CYCLES = 10
) (
    input wire logic        sys_clk_in,                 // Clock
    input wire logic        sys_rst_in,                 // Reset
    input wire logic [5:0]  avs_address_in,             // Address
    input wire logic        avs_write_in,               // Write
    input wire logic [31:0] avs_writedata_in,           // Data
    input wire logic [3:0]  avs_byteenable_in,          // Lanes
    input wire logic        cfg_rd_out,                 // Fetch
    input wire logic [31:0] actual_location_report_out, // Position
    input wire logic [31:0] ramp_up_duration_out,       // Ramp
    input wire logic        drive_inhibit_pin_out,      // Inhibit
    input wire logic        clear_pulse_pin_out,        // Clear
    input wire logic        cfg_changed_out             // Changed
);
    // ****************************************************
    // Helper state and assertions
    // ****************************************************
    logic [31:0] hi_cnt;
    logic [3:0]  since;
    logic [2:0]  code;
    logic        cmd_wr;
    logic        inh_wr;
    assign cmd_wr = avs_write_in && avs_address_in == mma_pkg::ADDR_CMD && avs_byteenable_in[0];
    assign inh_wr = avs_write_in && avs_address_in == mma_pkg::ADDR_INHIBIT && avs_byteenable_in == 4'hf;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) hi_cnt <= 32'h0;
        else hi_cnt <= clear_pulse_pin_out ? hi_cnt + 32'h1 : 32'h0;
    end
    // Cycles since the last command write, and its code
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            since <= 4'hf;
            code  <= 3'h0;
        end else if (cmd_wr) begin
            since <= 4'h0;
            code  <= avs_writedata_in[2:0];
        end else if (since != 4'hf) begin
            since <= since + 4'h1;
        end
    end
    a_clear_width: assert property ($fell(clear_pulse_pin_out) |-> hi_cnt == CLR_CYCLES)
        else $error("clear pulse width wrong");
    a_clear_bound: assert property (clear_pulse_pin_out |-> hi_cnt < CLR_CYCLES)
        else $error("clear pulse too long");
    a_clear_cause: assert property ($rose(clear_pulse_pin_out) |-> code == mma_pkg::CMD_CLEAR && since <= 4'h3)
        else $error("clear pulse without command");
    a_inhibit_on: assert property (inh_wr && avs_writedata_in[8] && avs_writedata_in[7:0] != 8'h00
        |-> ##2 drive_inhibit_pin_out)
        else $error("inhibit pin not set");
    a_inhibit_off: assert property (inh_wr && avs_writedata_in[8] && avs_writedata_in[7:0] == 8'h00
        |-> ##2 !drive_inhibit_pin_out)
        else $error("inhibit pin not cleared");
    a_inhibit_hold: assert property (inh_wr && !avs_writedata_in[8] |-> ##2 $stable(drive_inhibit_pin_out))
        else $error("inhibit pin moved while disabled");
    a_ramp_cause: assert property ($changed(ramp_up_duration_out) |-> code == mma_pkg::CMD_RAMP && since <= 4'h3)
        else $error("ramp time changed without command");
    a_report_cause: assert property ($changed(actual_location_report_out)
        |-> code == mma_pkg::CMD_LOAD_LOC && since <= 4'h3)
        else $error("position changed without load");
    a_fetch_cause: assert property (cfg_rd_out |-> code == mma_pkg::CMD_RELOAD && since <= 4'h5)
        else $error("table fetch without reload");
    a_change_after: assert property (cfg_changed_out |-> code == mma_pkg::CMD_RELOAD && since <= 4'h6)
        else $error("setup change without reload");
    c_clear: cover property ($fell(clear_pulse_pin_out));
    c_fetch: cover property (cfg_changed_out);
    c_inhibit: cover property ($rose(drive_inhibit_pin_out));
endmodule
bind mma_aux_commands mma_aux_props #(.CLR_CYCLES(CLR_CYCLES)) i_props (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .cfg_rd_out(cfg_rd_out), .actual_location_report_out(actual_location_report_out),
    .ramp_up_duration_out(ramp_up_duration_out), .drive_inhibit_pin_out(drive_inhibit_pin_out),
    .clear_pulse_pin_out(clear_pulse_pin_out), .cfg_changed_out(cfg_changed_out));
`default_nettype wire

/* File: bench/mma_cfg_table.sv */
// Configuration table model answering the block's fetches.
// Assumes word index in the low two pointer bits; bench loads words.
`default_nettype none
module mma_cfg_table (
    input wire logic        sys_clk_in,    // Clock
    input wire logic        sys_rst_in,    // Reset
    input wire logic [31:0] cfg_addr_in,   // Pointer
    input wire logic        cfg_rd_in,     // Fetch
    input wire logic        tbl_we_in,     // Load word
    input wire logic [1:0]  tbl_idx_in,    // Load index
    input wire logic [31:0] tbl_data_in,   // Load data
    output logic [31:0]     cfg_rdata_out  // Word out
);
    // ****************************************************
    // Table and fetch answer
    // ****************************************************
    logic [31:0] mem [4];
    always_ff @(posedge sys_clk_in) begin
        if (tbl_we_in) mem[tbl_idx_in] <= tbl_data_in;
    end
    // Word valid one cycle; otherwise a toggling pattern
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) cfg_rdata_out <= 32'ha5a5_5a5a;
        else if (cfg_rd_in) cfg_rdata_out <= mem[cfg_addr_in[1:0]];
        else cfg_rdata_out <= ~cfg_rdata_out;
    end
endmodule
`default_nettype wire

/* File: bench/mma_aux_commands_tb.sv */
// Self-checking bench for the auxiliary command block.
// Assumes the bound checker and the table model beside the design.
`default_nettype none
module mma_aux_commands_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************
    // Signals, instances and tasks
    // ****************************************************
    localparam int CLRC = 10;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, we = 1'b0;
    logic [5:0]  addr = 6'h00;
    logic [31:0] wdata = 32'h0, tdata = 32'h0, rdata, crd, cad, loc, rup, rdn, rsm;
    logic [3:0]  be = 4'hf;
    logic [1:0]  tidx = 2'h0;
    logic        wreq, crq, inh, clr, chg;
    int          n_errors = 0, cmp_count = 0, n_chg = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (chg === 1'b1) n_chg++;
    mma_aux_commands #(.CLR_CYCLES(CLRC)) i_dut (.sys_clk_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .cfg_rdata_in(crd), .cfg_addr_out(cad),
        .cfg_rd_out(crq), .actual_location_report_out(loc), .ramp_up_duration_out(rup),
        .ramp_down_duration_out(rdn), .smoothing_duration_out(rsm), .drive_inhibit_pin_out(inh),
        .clear_pulse_pin_out(clr), .cfg_changed_out(chg));
    mma_cfg_table i_tbl (.sys_clk_in(clk), .sys_rst_in(rst), .cfg_addr_in(cad), .cfg_rd_in(crq),
        .tbl_we_in(we), .tbl_idx_in(tidx), .tbl_data_in(tdata), .cfg_rdata_out(crd));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
        addr <= a; wdata <= d; wr <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
        addr <= a; rd <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        d = rdata;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] v;
        bus_rd(a, v);
        chk(nm, e, v);
    endtask
    task automatic wait_done(output logic [31:0] st);
        st = 32'h0;
        while (st[mma_pkg::STAT_DONE_BIT] !== 1'b1) bus_rd(mma_pkg::ADDR_STATUS, st);
    endtask
    task automatic cmd(input logic [2:0] c, output logic [31:0] st);
        bus_wr(mma_pkg::ADDR_CMD, {29'h0, c});
        wait_done(st);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
    // ****************************************************
    // Test sequence
    // ****************************************************
    initial begin
        logic [31:0] st;
        logic [31:0] pos [2];
        logic [31:0] iw [5];
        logic        ie [5];
        pos = '{32'h8000_0005, 32'h0000_0000};
        iw  = '{32'h105, 32'h100, 32'h0ff, 32'h1ff, 32'h000};
        ie  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("report", 32'h0, loc);
        rd_chk("status", mma_pkg::ADDR_STATUS, 32'h0);
        $display("Test reset done");
        for (int i = 0; i < 2; i++) begin
            bus_wr(mma_pkg::ADDR_NEW_POS, pos[i]);
            cmd(mma_pkg::CMD_LOAD_LOC, st);
            chk("load status", 32'h1, st);
            rd_chk("position", mma_pkg::ADDR_CUR_POS, pos[i]);
            chk("report", pos[i], loc);
        end
        $display("Test load done");
        bus_wr(mma_pkg::ADDR_RAMP_UP, 32'd100);
        bus_wr(mma_pkg::ADDR_RAMP_DN, 32'd200);
        bus_wr(mma_pkg::ADDR_SMOOTH, 32'd7);
        cmd(mma_pkg::CMD_RAMP, st);
        chk("ramp status", 32'h1, st);
        chk("ramp up", 32'd100, rup);
        chk("ramp down", 32'd200, rdn);
        chk("smoothing", 32'd7, rsm);
        bus_wr(mma_pkg::ADDR_RAMP_UP, 32'hffff_ffff);
        cmd(mma_pkg::CMD_RAMP, st);
        chk("bad ramp status", {16'h0, mma_pkg::ERR_BAD_RAMP, 8'h01}, st);
        chk("ramp kept", 32'd100, rup);
        for (int c = 5; c < 8; c++) begin
            cmd(c[2:0], st);
            chk("bad cmd status", {16'h0, mma_pkg::ERR_BAD_CMD, 8'h01}, st);
        end
        $display("Test ramp done");
        bus_wr(mma_pkg::ADDR_NEW_POS, 32'h0000_1234);
        bus_wr(mma_pkg::ADDR_CMD, {29'h0, mma_pkg::CMD_CLEAR});
        rd_chk("clear busy", mma_pkg::ADDR_STATUS, (32'h1 << mma_pkg::STAT_BUSY_BIT)
            | (32'h1 << mma_pkg::STAT_CLR_BIT));
        chk("clear pin", 32'h1, {31'h0, clr});
        bus_wr(mma_pkg::ADDR_CMD, {29'h0, mma_pkg::CMD_LOAD_LOC});
        wait_done(st);
        chk("clear status", 32'h1, st);
        rd_chk("position kept", mma_pkg::ADDR_CUR_POS, 32'h0);
        chk("clear pin low", 32'h0, {31'h0, clr});
        $display("Test clear done");
        for (int i = 0; i < 5; i++) begin
            bus_wr(mma_pkg::ADDR_INHIBIT, iw[i]);
            // Pin follows one edge after the register
            @(posedge clk);
            chk("inhibit", {31'h0, ie[i]}, {31'h0, inh});
        end
        $display("Test inhibit done");
        tidx <= 2'h2; tdata <= 32'hc0de_0001; we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        bus_wr(mma_pkg::ADDR_CFG_PTR, 32'h2);
        cmd(mma_pkg::CMD_RELOAD, st);
        chk("reload status", (32'h1 << mma_pkg::STAT_ACT_BIT) | 32'h1, st);
        rd_chk("active setup", mma_pkg::ADDR_ACT_CFG, 32'hc0de_0001);
        cmd(mma_pkg::CMD_RELOAD, st);
        chk("change count", 32'h1, n_chg);
        rd_chk("unmapped", 6'h30, 32'h0);
        rd_chk("spare", mma_pkg::ADDR_CFG_DATA, 32'h0);
        bus_wr(mma_pkg::ADDR_UNITS, 32'h1);
        rd_chk("units", mma_pkg::ADDR_UNITS, 32'h1);
        $display("Test reload done");
        complete_run();
    end
endmodule
`default_nettype wire
